// ### bsp_port.sv
// Synchronous control and data port of a pipelined burst static RAM.
// Function
// - Controller strobe low loads fresh address.
// - Strobe and select start read or write.
// - Strobe low, select high: power down.
// - Burst order low linear, high interleaved.
// - Sleep request enters retaining standby.
// - Sleep request masks every input but reset.
// - Data split into two or four lanes.
// - Write data captured on rising edge.
// - Parity lanes per width variant.
// - Processor strobe ignored when select high.
// - Burst step advances, high holds address.
// - Interleave XORs count, linear counts up.
// - All-lane write overrides lane enables.
`timescale 1ns/1ps
`include "bsp_cfg.svh"
module bsp_port (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Width variant, held static.
  input wire bsp_pkg::bsp_width_t widthSel,
  // Address and burst controls.
  input wire bsp_pkg::bsp_addr_t addrIn,
  input wire logic controller_addr_strobe_n,
  input wire logic processor_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic burstOrder,
  // Chip selects.
  input wire logic chipSelect_n,
  input wire logic second_chip_select,
  input wire logic third_chip_select_n,
  // Write controls.
  input wire logic all_lane_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [`BSP_LANES-1:0] lane_write_enable_n,
  input wire logic outEnable_n,
  // Standby.
  input wire logic sleep_request,
  // Data lanes, split into input, output and enable.
  input wire bsp_pkg::bsp_byte_t data_lane_a_in,
  input wire bsp_pkg::bsp_byte_t data_lane_b_in,
  input wire bsp_pkg::bsp_byte_t data_lane_c_in,
  input wire bsp_pkg::bsp_byte_t data_lane_d_in,
  input wire logic [`BSP_LANES-1:0] parityLaneIn,
  output logic [`BSP_LANES*`BSP_LANE_W-1:0] dataOut,
  output logic [`BSP_LANES-1:0] parityLaneOut,
  output logic [`BSP_LANES-1:0] dataOutEnable,
  // Status.
  output logic powerDown,
  output logic snoozing
);
  import bsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the asynchronous pins.
  ////////////////////////////////////////////////////////////////////////////

  // Sleep request and output enable come from outside the clock domain.
  logic sleepMeta; // First stage, read only by the second.
  logic sleepSync; // Usable sleep level.
  logic oeMeta; // First stage of output enable.
  logic oeSync_n; // Usable output enable.
  logic modeMeta; // First stage of burst order.
  logic modeSync; // Usable burst order; host keeps it static.

  // Two flops per asynchronous pin before any logic sees it.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sleepMeta <= 1'b0;
      sleepSync <= 1'b0;
      oeMeta <= 1'b1;
      oeSync_n <= 1'b1;
      modeMeta <= 1'b1;
      modeSync <= 1'b1;
    end else begin
      sleepMeta <= sleep_request;
      sleepSync <= sleepMeta;
      oeMeta <= outEnable_n;
      oeSync_n <= oeMeta;
      modeMeta <= burstOrder;
      modeSync <= modeMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control decode.
  ////////////////////////////////////////////////////////////////////////////

  logic selected; // All three chip selects active.
  logic procStart; // Processor strobe accepted.
  logic ctrlStart; // Controller strobe seen.
  logic loadAddr; // New external address this edge.
  logic writeAny; // Some lane is written this edge.
  logic [`BSP_LANES-1:0] laneWrite; // Lanes written this edge.
  logic [`BSP_LANES-1:0] lanePresent; // Lanes that exist in this width.
  bsp_state_t state; // Port state.
  bsp_addr_t baseAddr; // Registered external address.
  logic [`BSP_BURST_W-1:0] beat; // Burst beat count.
  logic [`BSP_BURST_W-1:0] nextBeat; // Beat that this edge's access uses.
  bsp_addr_t curAddr; // Address in use this cycle.

  assign selected = !chipSelect_n && second_chip_select && !third_chip_select_n;
  // Processor strobe needs the primary select low.
  assign procStart = !processor_addr_strobe_n && !chipSelect_n;
  assign ctrlStart = !controller_addr_strobe_n;
  assign loadAddr = ctrlStart || procStart;
  // The x18 part has only lanes a and b.
  assign lanePresent = (widthSel == `BSP_WIDTH_X18) ? 4'h3 : 4'hf;

  // Global write overrides the gate and per-lane enables.
  always_comb begin
    if (!all_lane_write_n) begin
      laneWrite = lanePresent;
    end else if (!byte_write_gate_n) begin
      laneWrite = ~lane_write_enable_n & lanePresent;
    end else begin
      laneWrite = 4'h0;
    end
  end

  // A processor-strobe start is always a read; writes wait for the next edge.
  assign writeAny = (|laneWrite) && !(procStart && processor_addr_strobe_n == 1'b0);

  // A continue beat already works on the stepped address, so the count leads the access.
  assign nextBeat = (state == BSP_ACTIVE && !burst_step_n) ? beat + `BSP_BURST_ONE : beat;

  // Burst address: interleave XORs the beat in, linear adds it.
  always_comb begin
    curAddr = baseAddr;
    if (modeSync) begin
      curAddr[`BSP_BURST_W-1:0] = baseAddr[`BSP_BURST_W-1:0] ^ nextBeat;
    end else begin
      curAddr[`BSP_BURST_W-1:0] = baseAddr[`BSP_BURST_W-1:0] + nextBeat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, address and burst counter.
  ////////////////////////////////////////////////////////////////////////////

  // Sleep wins over everything but reset so no other input can change state meanwhile.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= BSP_IDLE;
      baseAddr <= '0;
      beat <= `BSP_BURST_ZERO;
    end else if (sleepSync) begin
      state <= BSP_SNOOZE;
    end else begin
      case (state)
        BSP_SNOOZE: begin
          // Wake only once the request has dropped, into a quiet idle.
          state <= BSP_IDLE;
        end
        BSP_IDLE, BSP_ACTIVE: begin
          if (loadAddr) begin
            baseAddr <= addrIn;
            beat <= `BSP_BURST_ZERO;
            // Any select inactive at load time means deselect.
            state <= selected ? BSP_ACTIVE : BSP_IDLE;
          end else if (state == BSP_ACTIVE && !burst_step_n) begin
            beat <= nextBeat;
          end
        end
        default: begin
          state <= BSP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory array and data path.
  ////////////////////////////////////////////////////////////////////////////

  // One byte and one parity bit per lane per word; contents survive standby.
  bsp_byte_t memData [`BSP_LANES][`BSP_DEPTH];
  logic memPar [`BSP_LANES][`BSP_DEPTH];
  bsp_byte_t laneIn [`BSP_LANES];
  logic accessOk; // Access allowed at this edge.
  bsp_addr_t accAddr; // Address of this edge's access.

  assign laneIn[0] = data_lane_a_in;
  assign laneIn[1] = data_lane_b_in;
  assign laneIn[2] = data_lane_c_in;
  assign laneIn[3] = data_lane_d_in;
  assign accessOk = !sleepSync && state != BSP_SNOOZE &&
                    ((loadAddr && selected) || (!loadAddr && state == BSP_ACTIVE));
  assign accAddr = loadAddr ? addrIn : curAddr;

  // Write data is sampled on the rising edge like the other inputs.
  always_ff @(posedge mclk) begin
    if (accessOk && writeAny) begin
      for (int i = 0; i < `BSP_LANES; i++) begin
        if (laneWrite[i]) begin
          memData[i][accAddr] <= laneIn[i];
          // No parity storage on the x32 part.
          memPar[i][accAddr] <= (widthSel == `BSP_WIDTH_X32) ? 1'b0 : parityLaneIn[i];
        end
      end
    end
  end

  // Registered read data; the pipeline gives one cycle to first data.
  logic readValid;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dataOut <= '0;
      parityLaneOut <= 4'h0;
      readValid <= 1'b0;
    end else begin
      readValid <= accessOk && !writeAny;
      if (accessOk && !writeAny) begin
        for (int i = 0; i < `BSP_LANES; i++) begin
          dataOut[i*`BSP_LANE_W +: `BSP_LANE_W] <= memData[i][accAddr];
          parityLaneOut[i] <= (widthSel == `BSP_WIDTH_X32) ? 1'b0 : memPar[i][accAddr];
        end
      end
    end
  end

  // Drivers on only for a read, output enable low and not in standby.
  assign dataOutEnable = (readValid && !oeSync_n && state != BSP_SNOOZE && !sleepSync)
                         ? lanePresent : 4'h0;
  assign powerDown = (state == BSP_IDLE);
  assign snoozing = (state == BSP_SNOOZE);

endmodule : bsp_port

// ### bsp_cfg.svh
// Constants for the burst static RAM control port.
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH
`define BSP_ADDR_W 16
`define BSP_DEPTH 65536
`define BSP_LANE_W 8
`define BSP_LANES 4
`define BSP_BURST_W 2
`define BSP_BURST_ONE 2'h1
`define BSP_BURST_ZERO 2'h0
`define BSP_WIDTH_X18 2'h0
`define BSP_WIDTH_X32 2'h1
`define BSP_WIDTH_X36 2'h2
`endif

// ### bsp_pkg.sv
// Types for the burst static RAM control port.
`include "bsp_cfg.svh"
package bsp_pkg;
  typedef logic [`BSP_ADDR_W-1:0] bsp_addr_t;
  typedef logic [`BSP_LANE_W-1:0] bsp_byte_t;
  typedef logic [1:0] bsp_width_t;
  typedef enum logic [1:0] {
    BSP_IDLE = 2'h0,
    BSP_ACTIVE = 2'h1,
    BSP_SNOOZE = 2'h2
  } bsp_state_t;
endpackage : bsp_pkg

// ### bsp_port_chk.sv
// Concurrent checks on the burst port outputs.
`timescale 1ns/1ps
module bsp_port_chk (
  // Clock, reset and watched inputs.
  input wire logic mclk,
  input wire logic rst_b,
  input wire bsp_pkg::bsp_width_t widthSel,
  input wire logic controller_addr_strobe_n,
  input wire logic processor_addr_strobe_n,
  input wire logic chipSelect_n,
  input wire logic sleep_request,
  // Watched outputs.
  input wire logic [31:0] dataOut,
  input wire logic [3:0] parityLaneOut,
  input wire logic [3:0] dataOutEnable,
  input wire logic powerDown,
  input wire logic snoozing
);
  import bsp_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Sleep passes a synchroniser, so both windows allow for its delay.
  sequence s_asleep; sleep_request [*4]; endsequence
  sequence s_awake; !sleep_request [*6]; endsequence
  a_snooze_entry: assert property (s_asleep |-> snoozing)
    else $error("standby not entered");
  a_snooze_exit: assert property (s_awake |-> !snoozing)
    else $error("standby not left");
  a_snooze_quiet: assert property (snoozing |-> dataOutEnable == 4'h0)
    else $error("driving in standby");
  a_snooze_hold: assert property (snoozing && $past(snoozing) |-> $stable(dataOut))
    else $error("read data moved in standby");
  a_deselect_down: assert property (s_awake ##0 !controller_addr_strobe_n && chipSelect_n
    |=> powerDown) else $error("no power down");
  a_pas_ignored: assert property (s_awake ##0 powerDown && controller_addr_strobe_n
    && !processor_addr_strobe_n && chipSelect_n |=> powerDown) else $error("strobe taken");
  a_x32_parity: assert property (widthSel == 2'h1 |-> parityLaneOut == 4'h0)
    else $error("parity on narrow variant");
  a_x18_lanes: assert property (widthSel == 2'h0 |-> dataOutEnable[3:2] == 2'h0)
    else $error("upper lanes driven");
endmodule : bsp_port_chk
bind bsp_port bsp_port_chk bsp_port_chk_i (.*);

// ### bsp_ctl_model.sv
// Bus-side controller model that drives the port one beat at a time.
`timescale 1ns/1ps
module bsp_ctl_model (
  // Clock.
  input wire logic mclk,
  // Strobes, selects, write controls and sleep.
  output logic controller_addr_strobe_n, processor_addr_strobe_n, burst_step_n, chipSelect_n,
  output logic second_chip_select, third_chip_select_n, all_lane_write_n, byte_write_gate_n,
  output logic [3:0] lane_write_enable_n, output logic outEnable_n, sleep_request,
  // Address and write data.
  output bsp_pkg::bsp_addr_t addrIn,
  output bsp_pkg::bsp_byte_t data_lane_a_in, data_lane_b_in, data_lane_c_in, data_lane_d_in,
  output logic [3:0] parityLaneIn
);
  import bsp_pkg::*;
  // Extra selects and output enable stay active so that every read drives.
  assign second_chip_select = 1'b1;
  assign third_chip_select_n = 1'b0;
  assign outEnable_n = 1'b0;
  // Idle bus at time zero.
  initial begin
    {sleep_request, controller_addr_strobe_n, processor_addr_strobe_n} = 3'h3;
    {burst_step_n, chipSelect_n, all_lane_write_n, byte_write_gate_n} = 4'hf;
    {lane_write_enable_n, addrIn} = '1;
    {parityLaneIn, data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in} = '0;
  end
  // One beat: k is {sleep, strobe, processor strobe, step, select}; bw 0 is all-lane write.
  task automatic beat(input logic [4:0] k, input bsp_addr_t a, input logic [3:0] bw);
    @(posedge mclk);
    #1;
    {sleep_request, controller_addr_strobe_n, processor_addr_strobe_n} = k[4:2];
    {burst_step_n, chipSelect_n} = k[1:0];
    addrIn = a;
    all_lane_write_n = bw != 4'h0;
    // Lane controls are scrambled under an all-lane write, which must override them.
    byte_write_gate_n = all_lane_write_n ? bw == 4'hf : 1'($urandom);
    lane_write_enable_n = all_lane_write_n ? bw : 4'($urandom);
    // Data changes every beat, so a stale value never looks right by chance.
    {parityLaneIn, data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in} =
      36'({$urandom, $urandom});
  endtask : beat
endmodule : bsp_ctl_model

// ### bsp_port_test.sv
// Self-checking bench for the burst port and its controller model.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t %h %h", $time, a, b); end end
module bsp_port_test;
  import bsp_pkg::*;
  logic mclk = 0, rst_b = 0, burstOrder = 0, act = 0;
  bsp_width_t widthSel = 2'h0;
  int fails = 0, compares = 0;
  logic [35:0] mem [bsp_addr_t], q [$], e;
  bsp_addr_t ba, x, b;
  logic [1:0] bc;
  wire logic controller_addr_strobe_n, processor_addr_strobe_n, burst_step_n, chipSelect_n;
  wire logic second_chip_select, third_chip_select_n, all_lane_write_n, byte_write_gate_n;
  wire logic outEnable_n, sleep_request, powerDown, snoozing;
  wire logic [3:0] lane_write_enable_n, parityLaneIn, parityLaneOut, dataOutEnable;
  wire bsp_addr_t addrIn;
  wire bsp_byte_t data_lane_a_in, data_lane_b_in, data_lane_c_in, data_lane_d_in;
  wire logic [31:0] dataOut;
  // Lanes that exist on the chosen width; the 32-bit variant has no parity.
  wire logic [31:0] dm = widthSel == 2'h0 ? 32'h0000ffff : 32'hffffffff;
  wire logic [3:0] pm = widthSel == 2'h1 ? 4'h0 : widthSel == 2'h0 ? 4'h3 : 4'hf;
  bsp_ctl_model bsp_ctl_model_i (.*);
  bsp_port bsp_port_i (.*);
  initial forever #12.5 mclk = ~mclk;
  // Issue one beat and note what it should do to the array or the read queue.
  task automatic go(input logic [4:0] k, input bsp_addr_t a, input logic [3:0] bw);
    logic [35:0] d;
    bsp_ctl_model_i.beat(k, a, bw);
    d = {parityLaneIn, data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in};
    if (k[4]) act = 0;
    else if (!k[3] || !k[2] && !k[0]) begin
      act = !k[0];
      ba = a;
      bc = 2'h0;
    end else if (!k[1]) bc = bc + 2'h1;
    // A suspend beat in an open burst repeats the current address.
    if (!act) return;
    x = {ba[15:2], burstOrder ? ba[1:0] ^ bc : ba[1:0] + bc};
    if (bw == 4'hf || !k[2]) q.push_back(mem[x]);
    else for (int i = 0; i < 4; i++) if (bw == 4'h0 || !bw[i]) begin
      mem[x][8*i+:8] = d[8*i+:8];
      mem[x][32+i] = d[32+i];
    end
  endtask : go
  // Every driven read beat takes the oldest note off the queue.
  always @(negedge mclk) if (rst_b && |dataOutEnable) begin
    `CHK(q.size() != 0, 1'b1)
    e = q.size() != 0 ? q.pop_front() : '0;
    `CHK(dataOut & dm, e[31:0] & dm)
    `CHK(parityLaneOut & pm, e[35:32] & pm)
  end
  task automatic tally_and_finish();
    $display("Compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Each width takes about forty cycles, so this is generous.
  initial begin
    repeat (800) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'haeff));
    for (int v = 0; v < 3; v++) begin
      // Order and width change only while reset holds the memory still.
      rst_b = 0;
      widthSel = bsp_width_t'(v);
      burstOrder = v[0];
      repeat (4) @(posedge mclk);
      #1 rst_b = 1;
      b = 16'($urandom) & 16'hfffc;
      go(5'h06, b, 4'h0);
      repeat (3) go(5'h0d, b, 4'h0);
      go(5'h06, b + 16'h2, 4'($urandom % 15));
      repeat (3) go(5'h0d, b, 4'($urandom % 15));
      go(5'h0f, b, 4'($urandom % 15));
      go(5'h07, b, 4'hf);
      go(5'h0f, b, 4'hf);
      `CHK(powerDown, 1'b1)
      go(5'h06, b + 16'h1, 4'hf);
      repeat (4) go(5'h0d, b, 4'hf);
      go(5'h0f, b, 4'hf);
      go(5'h07, b, 4'hf);
      go(5'h0b, b, 4'hf);
      go(5'h0a, b + 16'h3, 4'hf);
      go(5'h07, b, 4'hf);
      // Writes attempted in standby must leave the array alone.
      repeat (4) go(5'h1f, b, 4'hf);
      `CHK(snoozing, 1'b1)
      repeat (3) go(5'h16, b, 4'h0);
      repeat (4) go(5'h0f, b, 4'hf);
      `CHK(snoozing, 1'b0)
      go(5'h06, b, 4'hf);
      go(5'h07, b, 4'hf);
      repeat (2) go(5'h0f, b, 4'hf);
      `CHK(q.size() == 0, 1'b1)
      $display("Width test %0d finished", v);
    end
    tally_and_finish();
  end
endmodule : bsp_port_test
